// ### hdl/thermal_control_one.sv
// thermal sensor control register one, with lockable fields and claim semaphore
// assumes a single-cycle register port on i_mclk from the host bridge
`timescale 1ns/100ps
`include "thermal_control_one_consts.svh"
module thermal_control_one (
  // clock and reset
  input  wire logic                                      i_mclk,
  input  wire logic                                      i_reset_n,
  input  wire logic                                      i_platform_reset_n,
  // register port
  input  wire thermal_control_one_pkg::reg_req_t         i_req,
  output logic [7:0]                                     o_rdata,
  output logic                                           o_rvalid,
  // lock from external lock register
  input  wire logic [7:0]                                i_thermal_lock_register,
  // sensor controls
  output thermal_control_one_pkg::thermal_control_one_t  o_ctrl,
  output logic                                           o_sensor_power_enable,
  output logic                                           o_analog_hyst_enable,
  output logic [3:0]                                     o_digital_hyst_amount,
  output logic                                           o_comparator_output_select
);
  import thermal_control_one_pkg::*;

  thermal_control_one_t ctrl_q, ctrl_d;
  logic [7:0]           rdata_q, rdata_d;
  logic                 rvalid_q, rvalid_d;
  logic                 hit, locked;

  assign hit    = (i_req.addr == `TC1_OFFSET);
  assign locked = i_thermal_lock_register[`TC1_LOCK_BIT];

  always_comb begin
    ctrl_d   = ctrl_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (i_req.rd) begin
      rvalid_d = 1'b1;
      rdata_d  = hit ? ctrl_q : 8'h00;
      // read returns old value, then claims
      if (hit) ctrl_d.sensor_claim_semaphore = 1'b1;
    end
    if (i_req.wr && hit) begin
      if (!locked) begin
        ctrl_d.sensor_power_enable      = i_req.wdata[`TC1_POWER_BIT];
        ctrl_d.comparator_output_select = i_req.wdata[`TC1_CMPSEL_BIT];
      end
      ctrl_d.analog_hyst_enable  = i_req.wdata[`TC1_AHYST_BIT];
      ctrl_d.digital_hyst_amount = i_req.wdata[`TC1_DHYST_MSB:`TC1_DHYST_LSB];
      if (i_req.wdata[`TC1_SEM_BIT]) ctrl_d.sensor_claim_semaphore = 1'b0;
    end
    if (!i_platform_reset_n) ctrl_d.sensor_claim_semaphore = 1'b0;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      ctrl_q   <= `TC1_RESET;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // semaphore has no field output of its own; it reaches o_ctrl, and o_rdata on a read
  assign o_ctrl                     = ctrl_q;
  assign o_sensor_power_enable      = ctrl_q.sensor_power_enable;
  assign o_analog_hyst_enable       = ctrl_q.analog_hyst_enable;
  assign o_digital_hyst_amount      = ctrl_q.digital_hyst_amount;
  assign o_comparator_output_select = ctrl_q.comparator_output_select;
  assign o_rdata                    = rdata_q;
  assign o_rvalid                   = rvalid_q;

  a_reset_zero: assert property (@(posedge i_mclk) !i_reset_n |=> ctrl_q == 8'h00)
    else $error("register not zero after reset");
  a_plt_clears: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !i_platform_reset_n |=> !ctrl_q.sensor_claim_semaphore)
    else $error("semaphore survived platform reset");
  a_power_out: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !(i_req.wr && hit && !locked) |=> $stable(o_sensor_power_enable))
    else $error("power enable mismatch");
  a_lock_holds: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    locked |=> $stable(ctrl_q.sensor_power_enable) && $stable(ctrl_q.comparator_output_select))
    else $error("locked field changed");
  a_ahyst_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_req.wr && hit |=> o_analog_hyst_enable == $past(i_req.wdata[6]))
    else $error("analog hysteresis not written");
  a_dhyst_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_req.wr && hit |=> o_digital_hyst_amount == $past(i_req.wdata[5:2]))
    else $error("digital hysteresis not written");
  a_cmp_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_req.wr && hit && !locked |=> o_comparator_output_select == $past(i_req.wdata[1]))
    else $error("comparator select not written");
  a_read_sets: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_req.rd && hit && !(i_req.wr && i_req.wdata[0]) && i_platform_reset_n
    |=> o_rvalid && ctrl_q.sensor_claim_semaphore)
    else $error("read did not set semaphore");
  a_w1c_sem: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_req.wr && hit && i_req.wdata[0] |=> !ctrl_q.sensor_claim_semaphore)
    else $error("write one did not clear semaphore");
endmodule // thermal_control_one

// ### hdl/thermal_control_one_consts.svh
// constants for the thermal sensor control register block
// assumes the includer wants offsets, field positions and reset values only
`ifndef THERMAL_CONTROL_ONE_CONSTS_SVH
`define THERMAL_CONTROL_ONE_CONSTS_SVH
`define TC1_OFFSET        12'h0cd8
`define TC1_RESET         8'h00
`define TC1_POWER_BIT     7
`define TC1_AHYST_BIT     6
`define TC1_DHYST_MSB     5
`define TC1_DHYST_LSB     2
`define TC1_CMPSEL_BIT    1
`define TC1_SEM_BIT       0
`define TC1_LOCK_BIT      7
`endif

// ### hdl/thermal_control_one_pkg.sv
// types for the thermal sensor control register block
// assumes the constants header is included by users that need numbers
package thermal_control_one_pkg;
  typedef struct packed {
    logic       sensor_power_enable;
    logic       analog_hyst_enable;
    logic [3:0] digital_hyst_amount;
    logic       comparator_output_select;
    logic       sensor_claim_semaphore;
  } thermal_control_one_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;
endpackage

// ### verification/testbench.sv
// self-checking bench for the thermal sensor control register
// assumes reads answer one cycle after the request edge
`timescale 1ns/100ps
`include "thermal_control_one_consts.svh"
module testbench;
  import thermal_control_one_pkg::*;
  logic i_mclk = 0, i_reset_n = 0, i_platform_reset_n = 1;
  reg_req_t i_req = '0;
  logic [7:0] i_thermal_lock_register = 8'h00, o_rdata;
  logic o_rvalid, o_sensor_power_enable, o_analog_hyst_enable, o_comparator_output_select;
  logic [3:0] o_digital_hyst_amount;
  thermal_control_one_t o_ctrl;
  int miscompares = 0, tests_run = 0;
  localparam logic [11:0] OFS = `TC1_OFFSET;
  thermal_control_one thermal_control_one_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_platform_reset_n(i_platform_reset_n), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_thermal_lock_register(i_thermal_lock_register),
    .o_ctrl(o_ctrl), .o_sensor_power_enable(o_sensor_power_enable),
    .o_analog_hyst_enable(o_analog_hyst_enable),
    .o_digital_hyst_amount(o_digital_hyst_amount),
    .o_comparator_output_select(o_comparator_output_select));
  initial forever #50 i_mclk = ~i_mclk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_mclk) i_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_mclk) i_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge i_mclk) i_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_mclk) i_req <= '0;
    #1 chk({7'h00, o_rvalid}, 8'h01);
    chk(o_rdata, exp);
  endtask
  // field outputs and register image
  task automatic outs(input logic [7:0] e);
    @(posedge i_mclk) #1;
    chk({o_sensor_power_enable, o_analog_hyst_enable, o_digital_hyst_amount,
      o_comparator_output_select, 1'b0}, {e[7:1], 1'b0});
    chk(o_ctrl, e);
  endtask
  task automatic t_claim;
    outs(8'h00);
    rd(OFS, 8'h00);
    rd(OFS, 8'h01);
  endtask
  task automatic t_fields;
    wr(OFS, 8'hdb);
    outs(8'hda);
    rd(OFS, 8'hda);
    wr(OFS, 8'h04);
    outs(8'h05);
    wr(OFS, 8'h83);
    outs(8'h82);
  endtask
  task automatic t_lock;
    @(posedge i_mclk) i_thermal_lock_register <= 8'h80;
    wr(OFS, 8'h7c);
    outs(8'hfe);
    rd(OFS, 8'hfe);
    @(posedge i_mclk) i_thermal_lock_register <= 8'h7f;
    wr(OFS, 8'h00);
    outs(8'h01);
  endtask
  task automatic t_other;
    wr(12'hcd9, 8'hff);
    rd(12'hcd9, 8'h00);
    outs(8'h01);
    @(posedge i_mclk) i_platform_reset_n <= 1'b0;
    @(posedge i_mclk) i_platform_reset_n <= 1'b1;
    outs(8'h00);
    rd(OFS, 8'h00);
    wr(OFS, 8'h01);
    rd(OFS, 8'h00);
  endtask
  initial begin
    repeat (2000) @(posedge i_mclk);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    t_claim();
    t_fields();
    t_lock();
    t_other();
    close_out();
  end
endmodule // testbench
